// *** inc/srd_pkg.sv ***
// Package: descriptor layout, AHB codes and state encodings for the receive descriptor handler
package srd_pkg;
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] PTR_OFFSET = 32'h0000_0004;
    localparam logic [31:0] DESC_STEP = 32'h0000_0008;
    localparam logic [31:0] TABLE_MASK = 32'hFFFF_FC00;
    localparam logic [31:0] INDEX_MASK = 32'h0000_03FF;
    localparam int CUT_BIT = 31;
    localparam int PAYLOAD_BIT = 30;
    localparam int HEADER_BIT = 29;
    localparam int ERRTERM_BIT = 28;
    localparam int IRQ_BIT = 27;
    localparam int WRAP_BIT = 26;
    localparam int ENABLE_BIT = 25;
    localparam int LEN_MSB = 24;
    localparam int LEN_W = 25;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RDCTRL = 3'h1,
        ST_RDPTR = 3'h3,
        ST_WAITPKT = 3'h2,
        ST_WRSTAT = 3'h6,
        ST_DONE = 3'h7
    } srd_state_type;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2
    } srd_op_type;
endpackage : srd_pkg

// *** inc/srd_mem_if.sv ***
// Interface: single-word memory request and answer between sequencer and AHB master
`timescale 1ns/1ps
`default_nettype none
interface srd_mem_if;
    logic req;
    srd_pkg::srd_op_type op;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic done;
    logic err;
    logic [31:0] rdata;
    modport client (output req, op, addr, wdata, input done, err, rdata);
    modport server (input req, op, addr, wdata, output done, err, rdata);
endinterface : srd_mem_if
`default_nettype wire

// *** hdl/srd_ahb_master.sv ***
// AHB master: one single-word read or write per request, reports completion
`timescale 1ns/1ps
`default_nettype none
module srd_ahb_master (
    input wire logic clk,
    input wire logic reset,
    srd_mem_if.server mem,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    input wire logic hgrant
);
    // Phase: 0 idle, 1 address phase, 2 data phase
    logic [1:0] phase_ff, nxt_phase;
    logic [31:0] addr_ff, nxt_addr;
    logic write_ff, nxt_write;
    logic [31:0] wdata_ff, nxt_wdata;
    logic done_ff, nxt_done;
    logic err_ff, nxt_err;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] htrans_ff, nxt_htrans;

    // Next-state: address phase waits for grant and hready, data phase waits for hready
    always_comb begin
        nxt_phase = phase_ff;
        nxt_addr = addr_ff;
        nxt_write = write_ff;
        nxt_wdata = wdata_ff;
        nxt_done = 1'b0;
        nxt_err = err_ff;
        nxt_rdata = rdata_ff;
        unique case (phase_ff)
            2'h0: begin
                if (mem.req && !done_ff) begin
                    nxt_phase = 2'h1;
                    nxt_addr = mem.addr;
                    nxt_write = (mem.op == srd_pkg::OP_WRITE);
                    nxt_wdata = mem.wdata;
                end
            end
            2'h1: begin
                if (hgrant && hready) begin
                    nxt_phase = 2'h2;
                end
            end
            2'h2: begin
                if (hready) begin
                    nxt_phase = 2'h0;
                    nxt_done = 1'b1;
                    nxt_err = (hresp != srd_pkg::HRESP_OKAY);
                    nxt_rdata = hrdata;
                end
            end
            default: begin
                nxt_phase = 2'h0;
            end
        endcase
        // Transfer type registered so the pin never glitches on a phase change
        nxt_htrans = (nxt_phase == 2'h1) ? srd_pkg::HTRANS_NONSEQ : srd_pkg::HTRANS_IDLE;
    end

    // Registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_ff <= 2'h0;
            addr_ff <= 32'h0000_0000;
            write_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            htrans_ff <= srd_pkg::HTRANS_IDLE;
        end else begin
            phase_ff <= nxt_phase;
            addr_ff <= nxt_addr;
            write_ff <= nxt_write;
            wdata_ff <= nxt_wdata;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            rdata_ff <= nxt_rdata;
            htrans_ff <= nxt_htrans;
        end
    end

    assign mem.done = done_ff;
    assign mem.err = err_ff;
    assign mem.rdata = rdata_ff;
    assign haddr = addr_ff;
    assign htrans = htrans_ff;
    assign hwrite = write_ff;
    assign hsize = srd_pkg::HSIZE_WORD;
    assign hwdata = wdata_ff;
endmodule : srd_ahb_master
`default_nettype wire

// *** hdl/srd_desc_seq.sv ***
// Descriptor sequencer: fetch, hand over buffer, write back status, advance pointer
`timescale 1ns/1ps
`default_nettype none
// Function
// - Control/status word sits at offset 0x0, buffer pointer word at 0x4.
// - All 32 pointer bits give the buffer address for packet bytes.
// - Bit 31 written one when packet was cut at maximum length, else zero.
// - Bit 30 written one on payload check error, else zero.
// - Bit 29 written one on header check error, else zero.
// - Bit 28 written one when packet ended with error termination.
// - Bit 27 with channel interrupt enable raises an interrupt on completion.
// - Bit 26 set makes the next descriptor the table base.
// - Wrap clear advances the descriptor pointer by 0x8.
// - Pointer returns to table base at the 1 KiB boundary regardless.
// - Received byte count goes into bits 24 down to 0.
// - Enable bit cleared with status; software reads length only afterwards.
// - Disabled descriptor read clears descriptors-available and stops fetching.
module srd_desc_seq (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] tableBase,
    input wire logic descAvailSet,
    input wire logic descAvailClr,
    input wire logic chanIrqEnable,
    input wire logic pktStart,
    input wire logic pktDone,
    input wire logic [24:0] pktByteCount,
    input wire logic pktLengthCut,
    input wire logic pktPayloadErr,
    input wire logic pktHeaderErr,
    input wire logic pktErrTerm,
    srd_mem_if.client mem,
    output logic [31:0] bufferPointer,
    output logic bufferValid,
    output logic descAvail,
    output logic [31:0] descPointer,
    output logic completionIrq,
    output logic pktReceived,
    output logic busError
);
    srd_pkg::srd_state_type state_ff, nxt_state;
    logic [31:0] ptr_ff, nxt_ptr;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] buf_ff, nxt_buf;
    logic avail_ff, nxt_avail;
    logic irq_ff, nxt_irq;
    logic rcvd_ff, nxt_rcvd;
    logic berr_ff, nxt_berr;
    logic [31:0] stat_ff, nxt_stat;
    logic valid_ff, nxt_valid;

    // Next descriptor address; the table index is kept inside 1 KiB
    function automatic logic [31:0] next_desc(input logic [31:0] cur,
                                               input logic [31:0] base,
                                               input logic wrap);
        logic [31:0] idx;
        idx = (cur & srd_pkg::INDEX_MASK) + srd_pkg::DESC_STEP;
        if (wrap || (idx > srd_pkg::INDEX_MASK)) begin
            next_desc = base & srd_pkg::TABLE_MASK;
        end else begin
            next_desc = (base & srd_pkg::TABLE_MASK) | idx;
        end
    endfunction : next_desc

    // Fetch address: table base above the 1 KiB index, pointer index below
    function automatic logic [31:0] desc_addr(input logic [31:0] cur,
                                               input logic [31:0] base);
        desc_addr = (base & srd_pkg::TABLE_MASK) | (cur & srd_pkg::INDEX_MASK);
    endfunction : desc_addr

    // Completion word: flags, enable cleared, count, built in one piece
    function automatic logic [31:0] status_word(input logic [31:0] ctrl,
                                                input logic cut, input logic pay,
                                                input logic hdr, input logic term,
                                                input logic [24:0] cnt);
        logic [31:0] w;
        w = ctrl;
        w[srd_pkg::CUT_BIT] = cut;
        w[srd_pkg::PAYLOAD_BIT] = pay;
        w[srd_pkg::HEADER_BIT] = hdr;
        w[srd_pkg::ERRTERM_BIT] = term;
        w[srd_pkg::ENABLE_BIT] = 1'b0;
        w[srd_pkg::LEN_MSB:0] = cnt;
        status_word = w;
    endfunction : status_word

    // Sequencer next-state; set of descriptors-available wins over clear
    always_comb begin
        nxt_state = state_ff;
        nxt_ptr = ptr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_buf = buf_ff;
        nxt_irq = 1'b0;
        nxt_rcvd = 1'b0;
        nxt_berr = 1'b0;
        nxt_stat = stat_ff;
        nxt_avail = avail_ff;
        if (descAvailClr) begin
            nxt_avail = 1'b0;
        end
        unique case (state_ff)
            srd_pkg::ST_IDLE: begin
                // Fetch only once a packet is pending and descriptors exist
                if (pktStart && avail_ff) begin
                    nxt_state = srd_pkg::ST_RDCTRL;
                end
            end
            srd_pkg::ST_RDCTRL: begin
                if (mem.done) begin
                    nxt_ctrl = mem.rdata;
                    if (mem.err) begin
                        nxt_berr = 1'b1;
                        nxt_state = srd_pkg::ST_IDLE;
                    end else if (!mem.rdata[srd_pkg::ENABLE_BIT]) begin
                        nxt_avail = 1'b0;
                        nxt_state = srd_pkg::ST_IDLE;
                    end else begin
                        nxt_state = srd_pkg::ST_RDPTR;
                    end
                end
            end
            srd_pkg::ST_RDPTR: begin
                if (mem.done) begin
                    nxt_buf = mem.rdata;
                    nxt_state = mem.err ? srd_pkg::ST_IDLE : srd_pkg::ST_WAITPKT;
                    nxt_berr = mem.err;
                end
            end
            srd_pkg::ST_WAITPKT: begin
                if (pktDone) begin
                    nxt_stat = status_word(ctrl_ff, pktLengthCut, pktPayloadErr,
                                           pktHeaderErr, pktErrTerm, pktByteCount);
                    nxt_state = srd_pkg::ST_WRSTAT;
                end
            end
            srd_pkg::ST_WRSTAT: begin
                if (mem.done) begin
                    nxt_state = srd_pkg::ST_DONE;
                    nxt_berr = mem.err;
                end
            end
            srd_pkg::ST_DONE: begin
                nxt_ptr = next_desc(ptr_ff, tableBase, ctrl_ff[srd_pkg::WRAP_BIT]);
                nxt_irq = ctrl_ff[srd_pkg::IRQ_BIT] && chanIrqEnable;
                nxt_rcvd = 1'b1;
                nxt_state = srd_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = srd_pkg::ST_IDLE;
            end
        endcase
        if (descAvailSet) begin
            nxt_avail = 1'b1;
        end
        // Buffer handed over while waiting for the packet end
        nxt_valid = (nxt_state == srd_pkg::ST_WAITPKT);
    end

    // Registers; pointer index starts at zero, the base is applied on every fetch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= srd_pkg::ST_IDLE;
            ptr_ff <= 32'h0000_0000;
            ctrl_ff <= 32'h0000_0000;
            buf_ff <= 32'h0000_0000;
            avail_ff <= 1'b0;
            irq_ff <= 1'b0;
            rcvd_ff <= 1'b0;
            berr_ff <= 1'b0;
            stat_ff <= 32'h0000_0000;
            valid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ptr_ff <= nxt_ptr;
            ctrl_ff <= nxt_ctrl;
            buf_ff <= nxt_buf;
            avail_ff <= nxt_avail;
            irq_ff <= nxt_irq;
            rcvd_ff <= nxt_rcvd;
            berr_ff <= nxt_berr;
            stat_ff <= nxt_stat;
            valid_ff <= nxt_valid;
        end
    end

    // Memory requests: reads at 0x0 then 0x4, one status write at 0x0
    always_comb begin
        mem.req = 1'b0;
        mem.op = srd_pkg::OP_NONE;
        mem.addr = desc_addr(ptr_ff, tableBase) + srd_pkg::CTRL_OFFSET;
        mem.wdata = stat_ff;
        unique case (state_ff)
            srd_pkg::ST_RDCTRL: begin
                mem.req = 1'b1;
                mem.op = srd_pkg::OP_READ;
            end
            srd_pkg::ST_RDPTR: begin
                mem.req = 1'b1;
                mem.op = srd_pkg::OP_READ;
                mem.addr = desc_addr(ptr_ff, tableBase) + srd_pkg::PTR_OFFSET;
            end
            srd_pkg::ST_WRSTAT: begin
                mem.req = 1'b1;
                mem.op = srd_pkg::OP_WRITE;
            end
            default: begin
                mem.req = 1'b0;
            end
        endcase
    end

    assign bufferPointer = buf_ff;
    assign bufferValid = valid_ff;
    assign descAvail = avail_ff;
    assign descPointer = ptr_ff;
    assign completionIrq = irq_ff;
    assign pktReceived = rcvd_ff;
    assign busError = berr_ff;

    // Checks
    chk_wrap_to_base: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_DONE && ctrl_ff[srd_pkg::WRAP_BIT])
        |=> (ptr_ff == (tableBase & srd_pkg::TABLE_MASK)))
        else $error("wrap did not return pointer to base");
    chk_pointer_step: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_DONE && !ctrl_ff[srd_pkg::WRAP_BIT]
         && ((ptr_ff & srd_pkg::INDEX_MASK) != 32'h0000_03F8)
         && ((ptr_ff & srd_pkg::TABLE_MASK) == (tableBase & srd_pkg::TABLE_MASK)))
        |=> (ptr_ff == $past(ptr_ff) + srd_pkg::DESC_STEP))
        else $error("pointer not advanced by one descriptor");
    chk_boundary_wrap: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_DONE
         && ((ptr_ff & srd_pkg::INDEX_MASK) == 32'h0000_03F8))
        |=> ((ptr_ff & srd_pkg::INDEX_MASK) == 32'h0000_0000))
        else $error("pointer crossed table boundary");
    chk_enable_cleared: assert property (@(posedge clk) disable iff (reset)
        (mem.req && mem.op == srd_pkg::OP_WRITE)
        |-> (!mem.wdata[srd_pkg::ENABLE_BIT]
             && mem.addr == ((tableBase & srd_pkg::TABLE_MASK) | (ptr_ff & srd_pkg::INDEX_MASK))))
        else $error("status write keeps enable set");
    chk_status_flags: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_WAITPKT && pktDone)
        |=> (stat_ff[srd_pkg::CUT_BIT] == $past(pktLengthCut)
             && stat_ff[srd_pkg::PAYLOAD_BIT] == $past(pktPayloadErr)
             && stat_ff[srd_pkg::HEADER_BIT] == $past(pktHeaderErr)
             && stat_ff[srd_pkg::ERRTERM_BIT] == $past(pktErrTerm)))
        else $error("status flags mismatch");
    chk_length_field: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_WAITPKT && pktDone)
        |=> (stat_ff[srd_pkg::LEN_MSB:0] == $past(pktByteCount)))
        else $error("byte count not recorded");
    chk_irq_pulse: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_DONE)
        |=> (completionIrq == ($past(ctrl_ff[srd_pkg::IRQ_BIT]) && $past(chanIrqEnable))))
        else $error("completion interrupt wrong");
    chk_disabled_stop: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_RDCTRL && mem.done && !mem.err
         && !mem.rdata[srd_pkg::ENABLE_BIT] && !descAvailSet)
        |=> (!descAvail && state_ff == srd_pkg::ST_IDLE) ##1 (state_ff != srd_pkg::ST_RDCTRL))
        else $error("fetch continued after disabled descriptor");
    chk_ptr_read: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_RDPTR && mem.done && !mem.err)
        |=> (bufferValid && bufferPointer == $past(mem.rdata)))
        else $error("buffer pointer not taken whole");
    chk_single_write: assert property (@(posedge clk) disable iff (reset)
        (state_ff == srd_pkg::ST_WRSTAT && mem.done) |=> (state_ff == srd_pkg::ST_DONE))
        else $error("status write not single");
    cov_full_packet: cover property (@(posedge clk) disable iff (reset)
        state_ff == srd_pkg::ST_DONE);
    cov_disabled_desc: cover property (@(posedge clk) disable iff (reset)
        state_ff == srd_pkg::ST_RDCTRL ##1 (state_ff == srd_pkg::ST_IDLE && !descAvail));
    cov_wrap_bit: cover property (@(posedge clk) disable iff (reset)
        state_ff == srd_pkg::ST_DONE && ctrl_ff[srd_pkg::WRAP_BIT]);
    cov_irq: cover property (@(posedge clk) disable iff (reset) completionIrq);
endmodule : srd_desc_seq
`default_nettype wire

// *** hdl/srd_rx_desc_top.sv ***
// Top: receive descriptor handler, sequencer plus AHB master, plain ports
`timescale 1ns/1ps
`default_nettype none
module srd_rx_desc_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] tableBase,
    input wire logic descAvailSet,
    input wire logic descAvailClr,
    input wire logic chanIrqEnable,
    input wire logic pktStart,
    input wire logic pktDone,
    input wire logic [24:0] pktByteCount,
    input wire logic pktLengthCut,
    input wire logic pktPayloadErr,
    input wire logic pktHeaderErr,
    input wire logic pktErrTerm,
    output logic [31:0] bufferPointer,
    output logic bufferValid,
    output logic descAvail,
    output logic [31:0] descPointer,
    output logic completionIrq,
    output logic pktReceived,
    output logic busError,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    input wire logic hgrant
);
    srd_mem_if memLink();

    // Descriptor sequencing
    srd_desc_seq uSeq (
        .clk(clk), .reset(reset), .tableBase(tableBase),
        .descAvailSet(descAvailSet), .descAvailClr(descAvailClr),
        .chanIrqEnable(chanIrqEnable), .pktStart(pktStart), .pktDone(pktDone),
        .pktByteCount(pktByteCount), .pktLengthCut(pktLengthCut),
        .pktPayloadErr(pktPayloadErr), .pktHeaderErr(pktHeaderErr),
        .pktErrTerm(pktErrTerm), .mem(memLink.client),
        .bufferPointer(bufferPointer), .bufferValid(bufferValid),
        .descAvail(descAvail), .descPointer(descPointer),
        .completionIrq(completionIrq), .pktReceived(pktReceived),
        .busError(busError)
    );

    // Bus access
    srd_ahb_master uAhb (
        .clk(clk), .reset(reset), .mem(memLink.server),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hresp(hresp), .hrdata(hrdata),
        .hgrant(hgrant)
    );
endmodule : srd_rx_desc_top
`default_nettype wire

// *** verif/srd_ahb_mem.sv ***
// Partner: AHB memory slave for descriptors, with wait states and error answers
`timescale 1ns/1ps
`default_nettype none
module srd_ahb_mem (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [1:0] waitStates,
    input wire logic [31:0] errAddr,
    output logic hready,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    output logic hgrant
);
    logic [31:0] mem [0:255];
    logic dPhase;
    logic dWrite;
    logic [31:0] dAddr;
    logic [1:0] cnt;
    logic [31:0] lastData;
    logic isErr;
    // Idle read bus shows the inverse of the last word, never a stale copy
    always_comb begin
        isErr = dPhase && (dAddr == errAddr);
        hready = !dPhase || (cnt == (isErr ? 2'h1 : waitStates));
        hresp = isErr ? 2'h1 : 2'h0;
        hrdata = (dPhase && !dWrite) ? mem[dAddr[9:2]] : ~lastData;
        hgrant = 1'b1;
    end
    // Plain always: the bench preloads the array from outside
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dPhase <= 1'b0;
            cnt <= 2'h0;
            lastData <= 32'h0;
        end else if (!hready) begin
            cnt <= cnt + 2'h1;
        end else begin
            if (dPhase && dWrite && !isErr)
                mem[dAddr[9:2]] <= hwdata;
            if (dPhase)
                lastData <= hrdata;
            dPhase <= (htrans == srd_pkg::HTRANS_NONSEQ);
            dAddr <= haddr;
            dWrite <= hwrite;
            cnt <= 2'h0;
        end
    end
endmodule : srd_ahb_mem
`default_nettype wire

// *** verif/srd_rx_desc_top_tb.sv ***
// Testbench: descriptor fetch, status write-back, pointer advance, refusals
`timescale 1ns/1ps
`default_nettype none
module srd_rx_desc_top_tb;
    logic clk, reset, descAvailSet, descAvailClr, chanIrqEnable, pktStart, pktDone;
    logic [24:0] pktByteCount;
    logic [3:0] flg;
    logic [31:0] bufferPointer, descPointer, haddr, hwdata, hrdata, errAddr, tblBase;
    logic bufferValid, descAvail, completionIrq, pktReceived, busError;
    logic hwrite, hready, hgrant;
    logic [1:0] htrans, hresp, waitStates;
    logic [2:0] hsize;
    int fails, compares, irqCnt, errCnt, wrCnt, reqCnt, n, errBase;

    srd_rx_desc_top dut_u (.clk(clk), .reset(reset), .tableBase(tblBase),
        .descAvailSet(descAvailSet), .descAvailClr(descAvailClr),
        .chanIrqEnable(chanIrqEnable), .pktStart(pktStart), .pktDone(pktDone),
        .pktByteCount(pktByteCount), .pktLengthCut(flg[3]), .pktPayloadErr(flg[2]),
        .pktHeaderErr(flg[1]), .pktErrTerm(flg[0]), .bufferPointer(bufferPointer),
        .bufferValid(bufferValid), .descAvail(descAvail), .descPointer(descPointer),
        .completionIrq(completionIrq), .pktReceived(pktReceived), .busError(busError),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hresp(hresp), .hrdata(hrdata), .hgrant(hgrant));
    srd_ahb_mem mem_u (.clk(clk), .reset(reset), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .waitStates(waitStates), .errAddr(errAddr),
        .hready(hready), .hresp(hresp), .hrdata(hrdata), .hgrant(hgrant));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Pulses last one cycle, so they are tallied at every rising edge
    always @(posedge clk) begin
        if (completionIrq === 1'b1) irqCnt++;
        if (busError === 1'b1) errCnt++;
        if (htrans === srd_pkg::HTRANS_NONSEQ && hready === 1'b1) begin
            reqCnt++;
            if (hwrite === 1'b1) wrCnt++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic bound(input int cnt);
        if (cnt >= 60) begin
            fails++;
            $display("[ERR] %0t wait timed out", $time);
            wrap_up();
        end
    endtask : bound
    // One packet through descriptor idx; pktStart drops once the buffer is handed over
    task automatic run_pkt(input int idx, input logic [3:0] fl, input logic [24:0] cnt,
                           input logic irqOn);
        logic [31:0] ctrl;
        int irq0, wr0;
        ctrl = mem_u.mem[idx * 2];
        irq0 = irqCnt;
        wr0 = wrCnt;
        chanIrqEnable = irqOn;
        pktStart = 1'b1;
        for (n = 0; n < 60 && bufferValid !== 1'b1; n++) @(negedge clk);
        bound(n);
        check(bufferPointer, mem_u.mem[idx * 2 + 1]);
        pktStart = 1'b0;
        flg = fl;
        pktByteCount = cnt;
        pktDone = 1'b1;
        @(negedge clk);
        pktDone = 1'b0;
        for (n = 0; n < 60 && pktReceived !== 1'b1; n++) @(negedge clk);
        bound(n);
        @(negedge clk);
        check(mem_u.mem[idx * 2], {fl, ctrl[27:26], 1'b0, cnt});
        check(32'(wrCnt - wr0), 32'h1);
        check(32'(irqCnt - irq0), {31'h0, ctrl[27] & irqOn});
    endtask : run_pkt

    initial begin
        {reset, descAvailSet, descAvailClr, chanIrqEnable, pktStart, pktDone} = 6'h20;
        {pktByteCount, flg, waitStates} = '0;
        errAddr = 32'hFFFF_FFFF;
        // A table away from address zero, so the base really takes part in fetches
        tblBase = 32'h0000_0C00;
        {fails, compares, irqCnt, errCnt, wrCnt, reqCnt} = '0;
        // Whole aligned table enabled, stale flags and length left in place
        for (int i = 0; i < 128; i++) begin
            mem_u.mem[2 * i] = (i % 3 == 0) ? 32'hFA00_1234 : 32'hF200_1234;
            mem_u.mem[2 * i + 1] = 32'h4000_0000 + 32'(i * 256);
        end
        repeat (4) @(negedge clk);
        reset = 1'b0;
        check({bufferValid, descAvail, completionIrq, pktReceived, htrans}, 32'h0);
        check(descPointer, 32'h0);
        check(32'(hsize), 32'(srd_pkg::HSIZE_WORD));
        {descAvailSet, descAvailClr} = 2'h3;
        @(negedge clk);
        {descAvailSet, descAvailClr} = 2'h0;
        @(negedge clk);
        check(descAvail, 32'h1);
        // Every flag pattern, slow memory in the upper half, boundary at the end
        for (int i = 0; i < 128; i++) begin
            waitStates = (i >= 64) ? 2'h2 : 2'h0;
            run_pkt(i, 4'(i), (i == 5) ? 25'h1FF_FFFF : 25'(i * 3 + 1), i[1]);
            check(descPointer, (i == 127) ? tblBase : (tblBase | 32'(8 * (i + 1))));
        end
        mem_u.mem[0] = 32'h0200_0000;
        mem_u.mem[2] = 32'h0600_0000;
        run_pkt(0, 4'h0, 25'h0, 1'b1);
        run_pkt(1, 4'h0, 25'h7, 1'b1);
        check(descPointer, tblBase);
        // Disabled descriptor: one read, flag dropped, no further fetches
        mem_u.mem[0] = 32'h0000_5678;
        n = reqCnt;
        pktStart = 1'b1;
        repeat (30) @(negedge clk);
        check(descAvail, 32'h0);
        check(32'(reqCnt - n), 32'h1);
        check(mem_u.mem[0], 32'h0000_5678);
        pktStart = 1'b0;
        // Bus error on the pointer word: no write-back
        mem_u.mem[0] = 32'h0200_0000;
        errAddr = tblBase | 32'h4;
        errBase = errCnt;
        descAvailSet = 1'b1;
        pktStart = 1'b1;
        @(negedge clk);
        descAvailSet = 1'b0;
        // The packet is spilled on a bus error, so pending drops in the pulse's own cycle
        for (n = 0; n < 60 && busError !== 1'b1; n++) @(negedge clk);
        pktStart = 1'b0;
        bound(n);
        repeat (20) @(negedge clk);
        check(32'(errCnt - errBase), 32'h1);
        check(mem_u.mem[0], 32'h0200_0000);
        check(bufferValid, 32'h0);
        // Software clear alone: no fetch while the flag stays low
        descAvailClr = 1'b1;
        @(negedge clk);
        descAvailClr = 1'b0;
        n = reqCnt;
        pktStart = 1'b1;
        repeat (10) @(negedge clk);
        check(descAvail, 32'h0);
        check(32'(reqCnt - n), 32'h0);
        pktStart = 1'b0;
        wrap_up();
    end
endmodule : srd_rx_desc_top_tb
`default_nettype wire
